// ---- mcx_map.svh ----
`ifndef MCX_MAP_SVH
`define MCX_MAP_SVH
// ==========================================================
// constants
`define MCX_PC_W 14
`define MCX_STACK_DEPTH 8
`define MCX_SP_W 3
`define MCX_BCD_LIMIT 4'h9
`define MCX_BCD_FIX 4'h6
`define MCX_ACC_RST 8'h00
`define MCX_PC_RST 14'h0000
`define MCX_WDT_W 16
`endif

// ---- mcx_pkg.sv ----
`include "mcx_map.svh"
package mcx_pkg;
   // ==========================================================
   // operation codes presented by the fetch stage
   typedef enum logic [4:0] {
      MCX_IDLE_OP = 5'h00,
      MCX_GUARD_CLEAR_FIRST = 5'h01,
      MCX_GUARD_CLEAR_SECOND = 5'h02,
      MCX_INVERT_MEM_OP = 5'h03,
      MCX_INVERT_TO_ACC_OP = 5'h04,
      MCX_BCD_ADJUST_OP = 5'h05,
      MCX_MINUS_ONE_MEM_OP = 5'h06,
      MCX_MINUS_ONE_TO_ACC_OP = 5'h07,
      MCX_PLUS_ONE_MEM_OP = 5'h08,
      MCX_PLUS_ONE_TO_ACC_OP = 5'h09,
      MCX_HALT_OP = 5'h0A,
      MCX_GOTO_OP = 5'h0B,
      MCX_COPY_MEM_TO_ACC_OP = 5'h0C,
      MCX_COPY_IMM_TO_ACC_OP = 5'h0D,
      MCX_COPY_ACC_TO_MEM_OP = 5'h0E,
      MCX_MERGE_MEM_OP = 5'h0F,
      MCX_MERGE_IMM_OP = 5'h10,
      MCX_MERGE_INTO_MEM_OP = 5'h11,
      MCX_SUBROUTINE_EXIT_OP = 5'h12,
      MCX_SUBROUTINE_EXIT_IMM_OP = 5'h13,
      MCX_IRQ_EXIT_OP = 5'h14,
      MCX_MEM_ROTATE_LEFT_OP = 5'h15,
      MCX_ROTATE_LEFT_TO_ACC_OP = 5'h16,
      MCX_PUSH_OP = 5'h17
   } mcx_op_t;

   typedef enum logic [2:0] {
      MCX_RUN = 3'b001,
      MCX_DUMMY = 3'b010,
      MCX_SLEEP = 3'b100
   } mcx_state_t;

   typedef struct packed {
      mcx_op_t op;
      logic [7:0] mem;
      logic [7:0] imm;
      logic [`MCX_PC_W-1:0] addr;
   } mcx_instr_t;

   typedef struct packed {
      logic zero;
      logic carry;
      logic half_carry;
      logic timeout;
      logic powerdown;
   } mcx_flags_t;
endpackage

// ---- mcx_core.sv ----
`timescale 1ns/1ps
`include "mcx_map.svh"
module mcx_core (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic instr_valid_i,
   input wire mcx_pkg::mcx_instr_t instr_i,
   input wire logic irq_pending_i,
   input wire logic wake_i,
   input wire logic wdt_timeout_i,
   output logic [7:0] acc_o,
   output logic [`MCX_PC_W-1:0] pc_o,
   output logic mem_we_o,
   output logic [7:0] mem_wdata_o,
   output mcx_pkg::mcx_flags_t flags_o,
   output logic global_irq_enable_o,
   output logic wdt_clear_o,
   output logic clk_gate_o,
   output logic irq_take_o,
   output logic busy_o
);
   import mcx_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction
   function automatic logic [7:0] rol1(input logic [7:0] v);
      rol1 = {v[6:0], v[7]}; // bit 7 wraps into bit 0
   endfunction

   // ==========================================================
   // state
   mcx_state_t state, next_state;
   logic [7:0] acc, next_acc;
   logic [`MCX_PC_W-1:0] pc, next_pc;
   logic [`MCX_PC_W-1:0] stack [`MCX_STACK_DEPTH];
   logic [`MCX_SP_W-1:0] sp, next_sp;
   logic push, pop;
   mcx_flags_t flags, next_flags;
   logic gie, next_gie;
   logic last_first, next_last_first;
   logic last_second, next_last_second;
   logic mem_we, next_mem_we;
   logic [7:0] mem_wdata, next_mem_wdata;
   logic wdt_clr, next_wdt_clr;
   logic irq_take, next_irq_take;
   logic [7:0] bcd_fix;
   logic [8:0] bcd_sum;

   // bcd correction term, one nibble at a time
   always_comb begin
      bcd_fix = 8'h00;
      if (acc[3:0] > `MCX_BCD_LIMIT || flags.half_carry) begin
         bcd_fix[3:0] = `MCX_BCD_FIX;
      end
      if (acc[7:4] > `MCX_BCD_LIMIT || flags.carry) begin
         bcd_fix[7:4] = `MCX_BCD_FIX;
      end
      bcd_sum = {1'b0, acc} + {1'b0, bcd_fix};
   end

   // next-state decode of one instruction
   always_comb begin
      next_state = state;
      next_acc = acc;
      next_pc = pc;
      next_sp = sp;
      push = 1'b0;
      pop = 1'b0;
      next_flags = flags;
      next_gie = gie;
      next_last_first = last_first;
      next_last_second = last_second;
      next_mem_we = 1'b0;
      next_mem_wdata = mem_wdata;
      next_wdt_clr = 1'b0;
      next_irq_take = 1'b0;
      case (state)
         MCX_SLEEP: begin
            // clock gated; only the wake pin restarts the core
            if (wake_i) begin
               next_state = MCX_RUN;
            end
         end
         MCX_DUMMY: begin
            // dummy slot while the new address is fetched
            next_state = MCX_RUN;
            if (irq_pending_i && gie) begin
               next_irq_take = 1'b1;
               next_gie = 1'b0;
            end
         end
         MCX_RUN: begin
            if (instr_valid_i) begin
               next_pc = pc + `MCX_PC_W'(1);
               // only the guard clear just taken stays armed
               next_last_first = (instr_i.op == MCX_GUARD_CLEAR_FIRST);
               next_last_second = (instr_i.op == MCX_GUARD_CLEAR_SECOND);
               case (instr_i.op)
                  MCX_GUARD_CLEAR_FIRST: begin
                     if (last_second) begin
                        next_wdt_clr = 1'b1;
                        next_flags.timeout = 1'b0;
                        next_flags.powerdown = 1'b0;
                     end
                  end
                  MCX_GUARD_CLEAR_SECOND: begin
                     if (last_first) begin
                        next_wdt_clr = 1'b1;
                        next_flags.timeout = 1'b0;
                        next_flags.powerdown = 1'b0;
                     end
                  end
                  MCX_INVERT_MEM_OP: begin
                     next_mem_we = 1'b1;
                     next_mem_wdata = ~instr_i.mem;
                     next_flags.zero = is_zero(~instr_i.mem);
                  end
                  MCX_INVERT_TO_ACC_OP: begin
                     next_acc = ~instr_i.mem;
                     next_flags.zero = is_zero(~instr_i.mem);
                  end
                  MCX_BCD_ADJUST_OP: begin
                     next_mem_we = 1'b1;
                     next_mem_wdata = bcd_sum[7:0];
                     // carry only ever set, keeps chained sums
                     if (bcd_sum[8]) begin
                        next_flags.carry = 1'b1;
                     end
                  end
                  MCX_MINUS_ONE_MEM_OP: begin
                     next_mem_we = 1'b1;
                     next_mem_wdata = instr_i.mem - 8'h01;
                     next_flags.zero = is_zero(instr_i.mem - 8'h01);
                  end
                  MCX_MINUS_ONE_TO_ACC_OP: begin
                     next_acc = instr_i.mem - 8'h01;
                     next_flags.zero = is_zero(instr_i.mem - 8'h01);
                  end
                  MCX_PLUS_ONE_MEM_OP: begin
                     next_mem_we = 1'b1;
                     next_mem_wdata = instr_i.mem + 8'h01;
                     next_flags.zero = is_zero(instr_i.mem + 8'h01);
                  end
                  MCX_PLUS_ONE_TO_ACC_OP: begin
                     next_acc = instr_i.mem + 8'h01;
                     next_flags.zero = is_zero(instr_i.mem + 8'h01);
                  end
                  MCX_HALT_OP: begin
                     next_state = MCX_SLEEP;
                     next_wdt_clr = 1'b1;
                     next_flags.timeout = 1'b0;
                     next_flags.powerdown = 1'b1;
                  end
                  MCX_GOTO_OP: begin
                     next_pc = instr_i.addr;
                     next_state = MCX_DUMMY;
                  end
                  MCX_COPY_MEM_TO_ACC_OP: begin
                     next_acc = instr_i.mem;
                  end
                  MCX_COPY_IMM_TO_ACC_OP: begin
                     next_acc = instr_i.imm;
                  end
                  MCX_COPY_ACC_TO_MEM_OP: begin
                     next_mem_we = 1'b1;
                     next_mem_wdata = acc;
                  end
                  MCX_MERGE_MEM_OP: begin
                     next_acc = acc | instr_i.mem;
                     next_flags.zero = is_zero(acc | instr_i.mem);
                  end
                  MCX_MERGE_IMM_OP: begin
                     next_acc = acc | instr_i.imm;
                     next_flags.zero = is_zero(acc | instr_i.imm);
                  end
                  MCX_MERGE_INTO_MEM_OP: begin
                     next_mem_we = 1'b1;
                     next_mem_wdata = acc | instr_i.mem;
                     next_flags.zero = is_zero(acc | instr_i.mem);
                  end
                  MCX_SUBROUTINE_EXIT_OP: begin
                     pop = 1'b1;
                     next_pc = stack[sp - `MCX_SP_W'(1)];
                     next_state = MCX_DUMMY;
                  end
                  MCX_SUBROUTINE_EXIT_IMM_OP: begin
                     pop = 1'b1;
                     next_pc = stack[sp - `MCX_SP_W'(1)];
                     next_acc = instr_i.imm;
                     next_state = MCX_DUMMY;
                  end
                  MCX_IRQ_EXIT_OP: begin
                     pop = 1'b1;
                     next_pc = stack[sp - `MCX_SP_W'(1)];
                     next_gie = 1'b1;
                     next_state = MCX_DUMMY;
                  end
                  MCX_MEM_ROTATE_LEFT_OP: begin
                     next_mem_we = 1'b1;
                     next_mem_wdata = rol1(instr_i.mem);
                  end
                  MCX_ROTATE_LEFT_TO_ACC_OP: begin
                     next_acc = rol1(instr_i.mem);
                  end
                  MCX_PUSH_OP: begin
                     push = 1'b1; // return address stacked; call target taken from instr_i.addr
                     next_pc = instr_i.addr;
                     next_state = MCX_DUMMY;
                  end
                  default: ;
               endcase
               // stack wraps within its depth
               if (push) begin
                  next_sp = sp + `MCX_SP_W'(1);
               end else if (pop) begin
                  next_sp = sp - `MCX_SP_W'(1);
               end
            end
         end
         default: next_state = MCX_RUN;
      endcase
      // watchdog set wins over a clear in the same cycle, so a
      // timeout is never lost to a coincident guard clear or halt
      if (wdt_timeout_i) begin
         next_flags.timeout = 1'b1;
      end
   end

   // ==========================================================
   // registers; clock enable freezes everything
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= MCX_RUN;
         acc <= `MCX_ACC_RST;
         pc <= `MCX_PC_RST;
         sp <= '0;
         flags <= '0;
         gie <= 1'b0;
         last_first <= 1'b0;
         last_second <= 1'b0;
         mem_we <= 1'b0;
         mem_wdata <= 8'h00;
         wdt_clr <= 1'b0;
         irq_take <= 1'b0;
      end else if (clk_en_i) begin
         state <= next_state;
         acc <= next_acc;
         pc <= next_pc;
         sp <= next_sp;
         flags <= next_flags;
         gie <= next_gie;
         last_first <= next_last_first;
         last_second <= next_last_second;
         mem_we <= next_mem_we;
         mem_wdata <= next_mem_wdata;
         wdt_clr <= next_wdt_clr;
         irq_take <= next_irq_take;
      end
   end

   // return address store, no reset needed
   always_ff @(posedge sys_clk_i) begin
      if (clk_en_i && push) begin
         stack[sp] <= pc + `MCX_PC_W'(1);
      end
   end

   assign acc_o = acc;
   assign pc_o = pc;
   assign mem_we_o = mem_we;
   assign mem_wdata_o = mem_wdata;
   assign flags_o = flags;
   assign global_irq_enable_o = gie;
   assign wdt_clear_o = wdt_clr;
   assign clk_gate_o = state[2]; // one-hot sleep bit, no decode after flop
   assign irq_take_o = irq_take;
   assign busy_o = state[1]; // one-hot dummy bit

   // ==========================================================
   // checks
   property p_repeat_no_clear;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && state == MCX_RUN && instr_valid_i &&
       instr_i.op == MCX_GUARD_CLEAR_FIRST && last_first) |=> !wdt_clr;
   endproperty
   a_repeat_no_clear: assert property (p_repeat_no_clear)
      else $error("repeated guard clear cleared watchdog");

   property p_halt_flags;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && state == MCX_RUN && instr_valid_i &&
       instr_i.op == MCX_HALT_OP) |=>
      (flags.powerdown && wdt_clr && state == MCX_SLEEP);
   endproperty
   a_halt_flags: assert property (p_halt_flags)
      else $error("halt did not set powerdown state");

   property p_goto_dummy;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && state == MCX_RUN && instr_valid_i &&
       instr_i.op == MCX_GOTO_OP) |=>
      (pc == $past(instr_i.addr) && state == MCX_DUMMY);
   endproperty
   a_goto_dummy: assert property (p_goto_dummy)
      else $error("jump did not load pc with dummy slot");

   property p_irq_exit;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && state == MCX_RUN && instr_valid_i &&
       instr_i.op == MCX_IRQ_EXIT_OP) |=> gie;
   endproperty
   a_irq_exit: assert property (p_irq_exit)
      else $error("irq exit did not enable interrupts");

   property p_rotate_acc;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && state == MCX_RUN && instr_valid_i &&
       instr_i.op == MCX_ROTATE_LEFT_TO_ACC_OP) |=>
      (!mem_we &&
       acc == {$past(instr_i.mem[6:0]), $past(instr_i.mem[7])});
   endproperty
   a_rotate_acc: assert property (p_rotate_acc)
      else $error("rotate to accumulator wrote memory or wrong value");

   property p_bcd_flags;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (clk_en_i && state == MCX_RUN && instr_valid_i &&
       instr_i.op == MCX_BCD_ADJUST_OP) |=>
      (mem_we && flags.zero == $past(flags.zero) &&
       flags.half_carry == $past(flags.half_carry));
   endproperty
   a_bcd_flags: assert property (p_bcd_flags)
      else $error("bcd adjust changed a flag other than carry");
endmodule // mcx_core

// ---- test_mcu_core_instruction_subset.sv ----
`timescale 1ns/1ps
`include "mcx_map.svh"
module test_mcu_core_instruction_subset;
   import mcx_pkg::*;
   // ==========================================================
   // signals
   logic sys_clk_i;
   logic resetn_i;
   logic clk_en_i;
   logic instr_valid_i;
   mcx_instr_t instr_i;
   logic irq_pending_i;
   logic wake_i;
   logic wdt_timeout_i;
   logic [7:0] acc_o;
   logic [`MCX_PC_W-1:0] pc_o;
   logic mem_we_o;
   logic [7:0] mem_wdata_o;
   mcx_flags_t flags_o;
   logic global_irq_enable_o;
   logic wdt_clear_o;
   logic clk_gate_o;
   logic irq_take_o;
   logic busy_o;
   int miscompares = 0;
   int checks = 0;
   int cycles = 0;
   int n;
   logic [7:0] exp_acc;
   logic [`MCX_PC_W-1:0] ret_pc;

   mcx_core i_mcx_core (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .clk_en_i(clk_en_i),
      .instr_valid_i(instr_valid_i),
      .instr_i(instr_i),
      .irq_pending_i(irq_pending_i),
      .wake_i(wake_i),
      .wdt_timeout_i(wdt_timeout_i),
      .acc_o(acc_o),
      .pc_o(pc_o),
      .mem_we_o(mem_we_o),
      .mem_wdata_o(mem_wdata_o),
      .flags_o(flags_o),
      .global_irq_enable_o(global_irq_enable_o),
      .wdt_clear_o(wdt_clear_o),
      .clk_gate_o(clk_gate_o),
      .irq_take_o(irq_take_o),
      .busy_o(busy_o)
   );

   // ==========================================================
   // clock and hang guard, ceiling far above the ~60 cycles used
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         tally_and_finish;
      end
   end

   // ==========================================================
   // tasks
   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // entered at a falling edge; the taking edge passes inside
   task automatic exec(input mcx_op_t op, input logic [7:0] m,
                       input logic [7:0] i, input logic [13:0] a);
      instr_valid_i = 1'b1;
      instr_i = '{op: op, mem: m, imm: i, addr: a};
      @(negedge sys_clk_i);
   endtask

   // one data op: destination, untouched acc, zero and carry
   task automatic row(input mcx_op_t op, input logic [7:0] m,
                      input logic [7:0] i, input logic to_mem,
                      input logic [7:0] val, input logic z, input logic c);
      exec(op, m, i, 14'h0000);
      if (!to_mem)
         exp_acc = val;
      chk("mem_we", to_mem, mem_we_o);
      if (to_mem)
         chk("mem_wdata", val, mem_wdata_o);
      chk("acc", exp_acc, acc_o);
      chk("zero", z, flags_o.zero);
      chk("carry", c, flags_o.carry);
      chk("half_carry", 1'b0, flags_o.half_carry);
      chk("busy", 1'b0, busy_o);
   endtask

   // call to 0300, dummy, then the return under test
   task automatic ret_chk(input mcx_op_t op, input logic [7:0] i,
                          input logic pend);
      ret_pc = pc_o + 14'h0001;
      exec(MCX_PUSH_OP, 8'h00, 8'h00, 14'h0300);
      chk("call_pc", 14'h0300, pc_o);
      exec(MCX_IDLE_OP, 8'h00, 8'h00, 14'h0000);
      irq_pending_i = pend;
      exec(op, 8'h00, i, 14'h0000);
      chk("ret_pc", ret_pc, pc_o);
      chk("ret_busy", 1'b1, busy_o);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      resetn_i = 1'b0;
      clk_en_i = 1'b1;
      instr_valid_i = 1'b0;
      instr_i = '0;
      irq_pending_i = 1'b0;
      wake_i = 1'b0;
      wdt_timeout_i = 1'b0;
      exp_acc = 8'h00;
      repeat (5) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      chk("rst_acc", 8'h00, acc_o);
      chk("rst_pc", 14'h0000, pc_o);
      chk("rst_flags", 5'h00, flags_o);
      chk("rst_gie", 1'b0, global_irq_enable_o);
      // bcd corrections 00, 06, 60 (nibble and carry), 66
      row(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'h45, 0, 8'h45, 0, 0);
      row(MCX_BCD_ADJUST_OP, 8'h00, 8'h00, 1, 8'h45, 0, 0);
      row(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'h0B, 0, 8'h0B, 0, 0);
      row(MCX_BCD_ADJUST_OP, 8'h00, 8'h00, 1, 8'h11, 0, 0);
      row(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'hA0, 0, 8'hA0, 0, 0);
      row(MCX_BCD_ADJUST_OP, 8'h00, 8'h00, 1, 8'h00, 0, 1);
      row(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'h12, 0, 8'h12, 0, 1);
      row(MCX_BCD_ADJUST_OP, 8'h00, 8'h00, 1, 8'h72, 0, 1);
      row(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'h9A, 0, 8'h9A, 0, 1);
      row(MCX_BCD_ADJUST_OP, 8'h00, 8'h00, 1, 8'h00, 0, 1);
      // moves, merges, inverts, steps, rotates
      row(MCX_COPY_MEM_TO_ACC_OP, 8'h00, 8'h00, 0, 8'h00, 0, 1);
      row(MCX_COPY_ACC_TO_MEM_OP, 8'h00, 8'h00, 1, 8'h00, 0, 1);
      row(MCX_MERGE_IMM_OP, 8'h00, 8'h00, 0, 8'h00, 1, 1);
      row(MCX_MERGE_MEM_OP, 8'hA5, 8'h00, 0, 8'hA5, 0, 1);
      row(MCX_MERGE_INTO_MEM_OP, 8'h5A, 8'h00, 1, 8'hFF, 0, 1);
      row(MCX_INVERT_TO_ACC_OP, 8'hFF, 8'h00, 0, 8'h00, 1, 1);
      row(MCX_INVERT_MEM_OP, 8'h0F, 8'h00, 1, 8'hF0, 0, 1);
      row(MCX_PLUS_ONE_TO_ACC_OP, 8'hFF, 8'h00, 0, 8'h00, 1, 1);
      row(MCX_PLUS_ONE_MEM_OP, 8'h7F, 8'h00, 1, 8'h80, 0, 1);
      row(MCX_MINUS_ONE_TO_ACC_OP, 8'h01, 8'h00, 0, 8'h00, 1, 1);
      row(MCX_MINUS_ONE_MEM_OP, 8'h00, 8'h00, 1, 8'hFF, 0, 1);
      row(MCX_MERGE_IMM_OP, 8'h00, 8'h00, 0, 8'h00, 1, 1);
      row(MCX_MEM_ROTATE_LEFT_OP, 8'h81, 8'h00, 1, 8'h03, 1, 1);
      row(MCX_ROTATE_LEFT_TO_ACC_OP, 8'h80, 8'h00,
          0, 8'h01, 1, 1);
      row(MCX_IDLE_OP, 8'hFF, 8'hFF, 0, 8'h01, 1, 1);
      // frozen core takes nothing
      clk_en_i = 1'b0;
      exec(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'h99, 14'h0000);
      chk("frozen_acc", exp_acc, acc_o);
      clk_en_i = 1'b1;
      // guard clears: only an alternating pair acts
      wdt_timeout_i = 1'b1;
      exec(MCX_IDLE_OP, 8'h00, 8'h00, 14'h0000);
      wdt_timeout_i = 1'b0;
      chk("timeout_set", 1'b1, flags_o.timeout);
      exec(MCX_GUARD_CLEAR_FIRST, 8'h00, 8'h00, 14'h0000);
      chk("timeout", 1'b1, flags_o.timeout);
      chk("wdt_clear", 1'b0, wdt_clear_o);
      exec(MCX_GUARD_CLEAR_FIRST, 8'h00, 8'h00, 14'h0000);
      chk("timeout", 1'b1, flags_o.timeout);
      chk("wdt_clear", 1'b0, wdt_clear_o);
      exec(MCX_GUARD_CLEAR_SECOND, 8'h00, 8'h00, 14'h0000);
      chk("timeout", 1'b0, flags_o.timeout);
      chk("wdt_clear", 1'b1, wdt_clear_o);
      exec(MCX_GUARD_CLEAR_SECOND, 8'h00, 8'h00, 14'h0000);
      chk("wdt_clear", 1'b0, wdt_clear_o);
      // reverse order pairs too; a coincident watchdog set wins
      wdt_timeout_i = 1'b1;
      exec(MCX_GUARD_CLEAR_FIRST, 8'h00, 8'h00, 14'h0000);
      wdt_timeout_i = 1'b0;
      chk("wdt_clear", 1'b1, wdt_clear_o);
      chk("timeout_set_wins", 1'b1, flags_o.timeout);
      // sleep: instructions refused, state kept until wake
      exec(MCX_HALT_OP, 8'h00, 8'h00, 14'h0000);
      chk("clk_gate", 1'b1, clk_gate_o);
      chk("powerdown", 1'b1, flags_o.powerdown);
      chk("timeout", 1'b0, flags_o.timeout);
      chk("wdt_clear", 1'b1, wdt_clear_o);
      exec(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'h77, 14'h0000);
      chk("sleep_acc", exp_acc, acc_o);
      instr_valid_i = 1'b0;
      wake_i = 1'b1;
      for (n = 0; n < 20 && clk_gate_o !== 1'b0; n++)
         @(negedge sys_clk_i);
      wake_i = 1'b0;
      chk("woken", 1'b0, clk_gate_o);
      chk("kept_acc", exp_acc, acc_o);
      exec(MCX_GUARD_CLEAR_FIRST, 8'h00, 8'h00, 14'h0000);
      chk("powerdown", 1'b1, flags_o.powerdown);
      exec(MCX_GUARD_CLEAR_SECOND, 8'h00, 8'h00, 14'h0000);
      chk("powerdown", 1'b0, flags_o.powerdown);
      // jump: dummy slot refuses the next instruction
      exec(MCX_GOTO_OP, 8'h00, 8'h00, 14'h1234);
      chk("goto_pc", 14'h1234, pc_o);
      chk("goto_busy", 1'b1, busy_o);
      chk("goto_carry", 1'b1, flags_o.carry);
      exec(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'h55, 14'h0000);
      chk("dummy_acc", exp_acc, acc_o);
      row(MCX_COPY_IMM_TO_ACC_OP, 8'h00, 8'h3C, 0, 8'h3C, 1, 1);
      // returns
      ret_chk(MCX_SUBROUTINE_EXIT_OP, 8'h00, 1'b0);
      chk("ret_acc", exp_acc, acc_o);
      exec(MCX_IDLE_OP, 8'h00, 8'h00, 14'h0000);
      ret_chk(MCX_SUBROUTINE_EXIT_IMM_OP, 8'h5C, 1'b0);
      chk("ret_imm_acc", 8'h5C, acc_o);
      chk("ret_imm_zero", 1'b1, flags_o.zero);
      exec(MCX_IDLE_OP, 8'h00, 8'h00, 14'h0000);
      ret_chk(MCX_IRQ_EXIT_OP, 8'h00, 1'b0);
      chk("gie", 1'b1, global_irq_enable_o);
      exec(MCX_IDLE_OP, 8'h00, 8'h00, 14'h0000);
      chk("irq_take", 1'b0, irq_take_o);
      ret_chk(MCX_IRQ_EXIT_OP, 8'h00, 1'b1);
      exec(MCX_IDLE_OP, 8'h00, 8'h00, 14'h0000);
      irq_pending_i = 1'b0;
      chk("irq_take", 1'b1, irq_take_o);
      chk("gie_taken", 1'b0, global_irq_enable_o);
      instr_valid_i = 1'b0;
      tally_and_finish;
   end
endmodule // test_mcu_core_instruction_subset
